// ### hw/dic_core.sv
`timescale 1ns/1ps
`include "dic_regs.svh"

// How it works
// - Inputs sampled once every 5 ms scan
// - Per-input polarity, normally open by default
// - Programmable 0-to-1 delay in milliseconds
// - Programmable 1-to-0 delay in milliseconds
// - AC option adds fixed 30 ms release
// - Internal logic sees inputs one scan later
// - Routed relay follows one further scan later
// - Per-relay normally open or closed polarity
// - Full reset opens every relay contact
// - Communication and protection resets keep relays
// - Relay commands update once per scan
module dic_core #(
	parameter int unsigned MS_CYCLES = `DIC_CLK_HZ / `DIC_MS_PER_S
) (
	input  wire logic                  SYS_CLK,
	input  wire logic                  RST_B,
	input  wire logic                  COMM_RST,
	input  wire logic                  PROT_RST,
	input  wire logic [`DIC_N_IN-1:0]  FIELD_IN,
	input  wire logic [`DIC_AW-1:0]    REG_ADDR,
	input  wire logic [`DIC_DW-1:0]    REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic      [`DIC_DW-1:0]    REG_RDATA,
	output logic      [`DIC_N_IN-1:0]  IN_STATE,
	output logic      [`DIC_N_IN-1:0]  LOGIC_STATE,
	output logic      [`DIC_N_OUT-1:0] RELAY_DRIVE,
	output logic                       SCAN_TICK
);

	// True when the address falls inside a block of per-channel registers
	function automatic logic in_block(
		input logic [`DIC_AW-1:0] a,
		input logic [`DIC_AW-1:0] base,
		input logic [`DIC_AW-1:0] n
	);
		return (a >= base) && (a < 8'(base + n));
	endfunction

	// Channel index within a block of per-channel registers
	function automatic logic [`DIC_SRC_W-1:0] blk_idx(
		input logic [`DIC_AW-1:0] a,
		input logic [`DIC_AW-1:0] base
	);
		logic [`DIC_AW-1:0] d;
		d = a - base;
		return d[`DIC_SRC_W-1:0];
	endfunction

	// Widen a narrow field into a read word, upper bits zero
	function automatic logic [`DIC_DW-1:0] rd_word(
		input logic [`DIC_DLY_W-1:0] v
	);
		return {{(`DIC_DW-`DIC_DLY_W){1'b0}}, v};
	endfunction

	localparam logic [`DIC_AW-1:0] N_IN_A  = 8'(`DIC_N_IN);
	localparam logic [`DIC_AW-1:0] N_OUT_A = 8'(`DIC_N_OUT);

	logic                          ms_tick;
	logic                          scan_tick;
	logic                          soft_clr;
	logic [`DIC_N_IN-1:0]          sync1;
	logic [`DIC_N_IN-1:0]          sync2;
	logic [`DIC_N_IN-1:0]          sync3;
	logic [`DIC_N_IN-1:0]          field_lvl;
	logic [`DIC_N_IN-1:0]          in_pol;
	logic [`DIC_N_IN-1:0]          in_ac;
	logic [`DIC_DLY_W-1:0]         act_dly  [`DIC_N_IN];
	logic [`DIC_DLY_W-1:0]         drop_dly [`DIC_N_IN];
	dic_pkg::dic_in_cfg_t          in_cfg   [`DIC_N_IN];
	logic [`DIC_N_OUT-1:0]         out_pol;
	logic [`DIC_N_OUT-1:0]         out_sw;
	dic_pkg::dic_out_src_t         out_src  [`DIC_N_OUT];
	logic [`DIC_N_OUT-1:0]         next_relay_cmd;
	logic [`DIC_DW-1:0]            next_rdata;

	// Common time base for scans and millisecond delays
	dic_scan_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.clk       (SYS_CLK),
		.rst_b     (RST_B),
		.ms_tick   (ms_tick),
		.scan_tick (scan_tick)
	);

	assign SCAN_TICK = scan_tick;

	// Communication and protection resets only drop pending input timing
	assign soft_clr = COMM_RST | PROT_RST;

	// Field pins cross in through three stages; first stage feeds only the second
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= FIELD_IN;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// A pin change is accepted once the second and third stages agree
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			field_lvl <= '0;
		end else begin
			for (int i = 0; i < `DIC_N_IN; i++) begin
				if (sync2[i] == sync3[i])
					field_lvl[i] <= sync3[i];
			end
		end
	end

	// Input polarity and AC option registers
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			in_pol <= {`DIC_N_IN{`DIC_RST_POL}};
			in_ac  <= {`DIC_N_IN{`DIC_RST_AC}};
		end else if (REG_WR) begin
			if (REG_ADDR == `DIC_A_IN_POL)
				in_pol <= REG_WDATA[`DIC_N_IN-1:0];
			if (REG_ADDR == `DIC_A_IN_AC)
				in_ac <= REG_WDATA[`DIC_N_IN-1:0];
		end
	end

	// Activation and drop-off delays, one millisecond per count
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < `DIC_N_IN; i++) begin
				act_dly[i]  <= `DIC_RST_DLY;
				drop_dly[i] <= `DIC_RST_DLY;
			end
		end else if (REG_WR) begin
			if (in_block(REG_ADDR, `DIC_A_ACT_BASE, N_IN_A))
				act_dly[blk_idx(REG_ADDR, `DIC_A_ACT_BASE)] <=
					REG_WDATA[`DIC_DLY_W-1:0];
			if (in_block(REG_ADDR, `DIC_A_DROP_BASE, N_IN_A))
				drop_dly[blk_idx(REG_ADDR, `DIC_A_DROP_BASE)] <=
					REG_WDATA[`DIC_DLY_W-1:0];
		end
	end

	// Relay polarity, software command and source selection
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_pol <= {`DIC_N_OUT{`DIC_RST_POL}};
			out_sw  <= '0;
			for (int o = 0; o < `DIC_N_OUT; o++)
				out_src[o] <= '0;
		end else if (REG_WR) begin
			if (REG_ADDR == `DIC_A_OUT_POL)
				out_pol <= REG_WDATA[`DIC_N_OUT-1:0];
			if (REG_ADDR == `DIC_A_OUT_SW)
				out_sw <= REG_WDATA[`DIC_N_OUT-1:0];
			if (in_block(REG_ADDR, `DIC_A_SRC_BASE, N_OUT_A)) begin
				out_src[blk_idx(REG_ADDR, `DIC_A_SRC_BASE)].route_en <=
					REG_WDATA[`DIC_SRC_EN_BIT];
				out_src[blk_idx(REG_ADDR, `DIC_A_SRC_BASE)].idx <=
					REG_WDATA[`DIC_SRC_W-1:0];
			end
		end
	end

	// One conditioner per input channel
	for (genvar g = 0; g < `DIC_N_IN; g++) begin : g_in
		assign in_cfg[g] = '{
			pol:  in_pol[g],
			ac:   in_ac[g],
			act:  act_dly[g],
			drop: drop_dly[g]
		};

		dic_input_chan u_chan (
			.clk       (SYS_CLK),
			.rst_b     (RST_B),
			.clr       (soft_clr),
			.ms_tick   (ms_tick),
			.scan_tick (scan_tick),
			.energised (field_lvl[g]),
			.cfg       (in_cfg[g]),
			.state     (IN_STATE[g])
		);
	end

	// Internal logic takes its copy one scan behind the input state
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			LOGIC_STATE <= '0;
		else if (scan_tick)
			LOGIC_STATE <= IN_STATE;
	end

	// Active command per relay: a routed input or the software bit
	always_comb begin
		for (int o = 0; o < `DIC_N_OUT; o++) begin
			if (out_src[o].route_en)
				next_relay_cmd[o] = LOGIC_STATE[out_src[o].idx];
			else
				next_relay_cmd[o] = out_sw[o];
		end
	end

	// Coil drive takes the command straight from the logic copy, so a routed
	// input costs one scan here and no more; a second command stage would
	// push field-to-coil past three scans. Only the hard reset clears it, so
	// soft resets never open a closed contact, and a hard reset always opens
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			RELAY_DRIVE <= '0;
		else if (scan_tick)
			RELAY_DRIVE <= next_relay_cmd ^ out_pol;
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = '0;
		if (REG_ADDR == `DIC_A_IN_POL)
			next_rdata[`DIC_N_IN-1:0] = in_pol;
		else if (REG_ADDR == `DIC_A_IN_AC)
			next_rdata[`DIC_N_IN-1:0] = in_ac;
		else if (REG_ADDR == `DIC_A_IN_STATE)
			next_rdata[`DIC_N_IN-1:0] = IN_STATE;
		else if (REG_ADDR == `DIC_A_LOGIC)
			next_rdata[`DIC_N_IN-1:0] = LOGIC_STATE;
		else if (REG_ADDR == `DIC_A_OUT_POL)
			next_rdata[`DIC_N_OUT-1:0] = out_pol;
		else if (REG_ADDR == `DIC_A_OUT_SW)
			next_rdata[`DIC_N_OUT-1:0] = out_sw;
		else if (REG_ADDR == `DIC_A_OUT_STATE)
			next_rdata[`DIC_N_OUT-1:0] = RELAY_DRIVE;
		else if (in_block(REG_ADDR, `DIC_A_ACT_BASE, N_IN_A))
			next_rdata = rd_word(act_dly[blk_idx(REG_ADDR, `DIC_A_ACT_BASE)]);
		else if (in_block(REG_ADDR, `DIC_A_DROP_BASE, N_IN_A))
			next_rdata = rd_word(drop_dly[blk_idx(REG_ADDR, `DIC_A_DROP_BASE)]);
		else if (in_block(REG_ADDR, `DIC_A_SRC_BASE, N_OUT_A)) begin
			next_rdata[`DIC_SRC_EN_BIT] =
				out_src[blk_idx(REG_ADDR, `DIC_A_SRC_BASE)].route_en;
			next_rdata[`DIC_SRC_W-1:0] =
				out_src[blk_idx(REG_ADDR, `DIC_A_SRC_BASE)].idx;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			REG_RDATA <= '0;
		else if (REG_RD)
			REG_RDATA <= next_rdata;
		else
			REG_RDATA <= '0;
	end

endmodule

// ### hw/dic_input_chan.sv
`timescale 1ns/1ps
`include "dic_regs.svh"

module dic_input_chan (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                clr,
	input  wire logic                ms_tick,
	input  wire logic                scan_tick,
	input  wire logic                energised,
	input  dic_pkg::dic_in_cfg_t     cfg,
	output logic                     state
);

	dic_pkg::dic_state_t st;
	logic [20:0]         elapsed;
	logic [20:0]         limit;
	logic                target;

	// Polarity turns the energised level into the logical level
	assign target = energised ^ cfg.pol;

	// Rising uses the activation delay, falling the drop-off delay plus the AC hold when AC is set
	always_comb begin
		if (!state)
			limit = cfg.act;
		else if (cfg.ac)
			limit = cfg.drop + 21'(`DIC_AC_HOLD_MS);
		else
			limit = cfg.drop;
	end

	// Timer runs only while the level differs; a return cancels it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st      <= dic_pkg::DIC_ST_STABLE;
			elapsed <= `DIC_RST_DLY;
		end else if (clr || target == state) begin
			st      <= dic_pkg::DIC_ST_STABLE;
			elapsed <= `DIC_RST_DLY;
		end else begin
			case (st)
				dic_pkg::DIC_ST_STABLE: begin
					st <= dic_pkg::DIC_ST_TIMING;
				end
				dic_pkg::DIC_ST_TIMING: begin
					// Saturate so a long wait never wraps back to zero
					if (ms_tick && elapsed != {`DIC_DLY_W{1'b1}})
						elapsed <= elapsed + 21'h1;
				end
				default: begin
					st <= dic_pkg::DIC_ST_STABLE;
				end
			endcase
		end
	end

	// State only moves on a scan, once the delay has run out
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			state <= 1'b0;
		else if (scan_tick && target != state && elapsed >= limit)
			state <= target;
	end

endmodule

// ### hw/dic_scan_timer.sv
`timescale 1ns/1ps
`include "dic_regs.svh"

module dic_scan_timer #(
	parameter int unsigned MS_CYCLES = `DIC_CLK_HZ / `DIC_MS_PER_S
) (
	input  wire logic clk,
	input  wire logic rst_b,
	output logic      ms_tick,
	output logic      scan_tick
);

	logic [23:0] cyc;
	logic [2:0]  ms_cnt;

	// Millisecond divider; ms_tick is a one-cycle enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc     <= 24'h0;
			ms_tick <= 1'b0;
		end else if (cyc == 24'(MS_CYCLES - 1)) begin
			cyc     <= 24'h0;
			ms_tick <= 1'b1;
		end else begin
			cyc     <= cyc + 24'h1;
			ms_tick <= 1'b0;
		end
	end

	// Scan divider counts whole milliseconds so scan and delays stay in step
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt    <= 3'h0;
			scan_tick <= 1'b0;
		end else if (ms_tick && ms_cnt == 3'(`DIC_SCAN_MS - 1)) begin
			ms_cnt    <= 3'h0;
			scan_tick <= 1'b1;
		end else begin
			if (ms_tick)
				ms_cnt <= ms_cnt + 3'h1;
			scan_tick <= 1'b0;
		end
	end

endmodule

// ### shared/dic_pkg.sv
package dic_pkg;

	// Per input channel settings
	typedef struct packed {
		logic        pol;
		logic        ac;
		logic [20:0] act;
		logic [20:0] drop;
	} dic_in_cfg_t;

	// Per relay channel source selection
	typedef struct packed {
		logic       route_en;
		logic [2:0] idx;
	} dic_out_src_t;

	// Input channel timing states, one-hot
	typedef enum logic [1:0] {
		DIC_ST_STABLE = 2'b01,
		DIC_ST_TIMING = 2'b10
	} dic_state_t;

endpackage

// ### shared/dic_regs.svh
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH

// Channel counts and widths
`define DIC_N_IN        8
`define DIC_N_OUT       5
`define DIC_AW          8
`define DIC_DW          32
`define DIC_DLY_W       21
`define DIC_SRC_W       3

// Timing in its own units
`define DIC_CLK_HZ      20000000
`define DIC_MS_PER_S    1000
`define DIC_SCAN_MS     5
`define DIC_AC_HOLD_MS  30

// Register offsets (word index on the plain port)
`define DIC_A_IN_POL    8'h00
`define DIC_A_IN_AC     8'h01
`define DIC_A_IN_STATE  8'h02
`define DIC_A_LOGIC     8'h03
`define DIC_A_OUT_POL   8'h04
`define DIC_A_OUT_SW    8'h05
`define DIC_A_OUT_STATE 8'h06
`define DIC_A_ACT_BASE  8'h08
`define DIC_A_DROP_BASE 8'h10
`define DIC_A_SRC_BASE  8'h18

// Field positions of an output source register
`define DIC_SRC_EN_BIT  4

// Reset values
`define DIC_RST_POL     1'b0
`define DIC_RST_AC      1'b0
`define DIC_RST_DLY     21'h0

`endif

// ### verif/dic_core_bench.sv
`timescale 1ns/1ps
module dic_core_bench;
	localparam int unsigned MS = 4;
	logic        clk, rst_b, comm, prot, wr, rd, tick;
	logic [7:0]  want, field, addr, in_st, lg_st;
	logic [31:0] wdata, rdata;
	logic [4:0]  drive, contact;
	int          n_fail, n_checks;
	logic [7:0]  zero_a [7] = '{8'h00, 8'h01, 8'h04, 8'h07, 8'h0a, 8'h12, 8'h20};

	dic_core #(.MS_CYCLES(MS)) u_dic_core (
		.SYS_CLK(clk), .RST_B(rst_b), .COMM_RST(comm), .PROT_RST(prot),
		.FIELD_IN(field), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .IN_STATE(in_st), .LOGIC_STATE(lg_st),
		.RELAY_DRIVE(drive), .SCAN_TICK(tick));
	dic_field_model #(.LAG(2)) u_dic_field_model (
		.clk(clk), .want(want), .coil(drive), .field(field), .contact(contact));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", exp, rdata);
	endtask

	// Wait for n scan ticks, then let their updates land
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			while (tick !== 1'b1) @(posedge clk);
		end
		#1;
	endtask

	task automatic sc_scan();
		tk(1);
		want[0] = 1'b1;
		tk(1);
		chk("in", 1, in_st[0]);
		chk("logic", 0, lg_st[0]);
		tk(1);
		chk("logic", 1, lg_st[0]);
		rd_chk(8'h02, 32'h1);
		rd_chk(8'h03, 32'h1);
		wr_reg(8'h00, 32'h2);
		tk(2);
		chk("in", 1, in_st[1]);
	endtask

	// Seven ms both ways on channel 2, then a bounce that must restart timing
	task automatic sc_delay();
		wr_reg(8'h0a, 32'h7);
		wr_reg(8'h12, 32'h7);
		rd_chk(8'h0a, 32'h7);
		tk(1);
		want[2] = 1'b1;
		tk(1);
		chk("in", 0, in_st[2]);
		tk(1);
		chk("in", 1, in_st[2]);
		want[2] = 1'b0;
		tk(1);
		chk("in", 1, in_st[2]);
		tk(1);
		chk("in", 0, in_st[2]);
		want[2] = 1'b1;
		tk(1);
		want[2] = 1'b0;
		tk(1);
		want[2] = 1'b1;
		tk(1);
		chk("in", 0, in_st[2]);
		tk(1);
		chk("in", 1, in_st[2]);
	endtask

	task automatic sc_ac();
		wr_reg(8'h01, 32'h8);
		tk(1);
		want[3] = 1'b1;
		tk(1);
		want[3] = 1'b0;
		tk(5);
		chk("in", 1, in_st[3]);
		tk(2);
		chk("in", 0, in_st[3]);
	endtask

	// Relay 0 follows input 4; relay 1 closed at rest; relay 2 by software
	task automatic sc_relay();
		wr_reg(8'h18, 32'h14);
		tk(1);
		want[4] = 1'b1;
		tk(2);
		chk("relay", 0, contact[0]);
		tk(1);
		chk("relay", 1, contact[0]);
		wr_reg(8'h04, 32'h2);
		wr_reg(8'h05, 32'h4);
		tk(3);
		chk("relay", 5'h07, contact);
		rd_chk(8'h06, 32'h7);
	endtask

	task automatic sc_resets();
		@(posedge clk);
		comm <= 1'b1;
		@(posedge clk);
		comm <= 1'b0;
		prot <= 1'b1;
		@(posedge clk);
		prot <= 1'b0;
		tk(2);
		chk("relay", 5'h07, contact);
		rd_chk(8'h04, 32'h2);
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		#1 chk("relay", 0, contact);
		@(posedge clk);
		rst_b <= 1'b1;
		tk(2);
		chk("relay", 0, contact);
		rd_chk(8'h04, 32'h0);
	endtask

	task automatic tally_and_finish();
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Whole run is some thirty-five scans; allow plenty more
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		{rst_b, comm, prot, wr, rd, want, addr, wdata} = '0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		foreach (zero_a[i]) rd_chk(zero_a[i], 32'h0);
		sc_scan();
		sc_delay();
		sc_ac();
		sc_relay();
		sc_resets();
		tally_and_finish();
	end
endmodule

// ### verif/dic_core_sva.sv
`timescale 1ns/1ps
module dic_core_sva #(
	parameter int unsigned MS_CYCLES = 20000
) (
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	input wire logic        COMM_RST,
	input wire logic        PROT_RST,
	input wire logic [7:0]  REG_ADDR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic [7:0]  IN_STATE,
	input wire logic [7:0]  LOGIC_STATE,
	input wire logic [4:0]  RELAY_DRIVE,
	input wire logic        SCAN_TICK
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	int unsigned cnt;
	logic        seen;
	// Cycles since the last scan tick; first tick after reset has no reference
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt <= 0;
			seen <= 1'b0;
		end else if (SCAN_TICK) begin
			cnt <= 0;
			seen <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Scan edge and the cycle where its updates show
	sequence s_tick;
		SCAN_TICK ##1 1'b1;
	endsequence
	property p_period;
		SCAN_TICK && seen |-> cnt == 5 * MS_CYCLES - 1;
	endproperty
	property p_bound;
		seen |-> cnt < 5 * MS_CYCLES;
	endproperty
	// First tick after reset lands two cycles late: divider restart plus register
	property p_first;
		!seen |-> cnt <= 5 * MS_CYCLES + 1;
	endproperty
	property p_in_scan;
		$changed(IN_STATE) |-> $past(SCAN_TICK);
	endproperty
	property p_logic;
		s_tick |-> LOGIC_STATE == $past(IN_STATE);
	endproperty
	property p_logic_hold;
		$changed(LOGIC_STATE) |-> $past(SCAN_TICK);
	endproperty
	property p_relay;
		$changed(RELAY_DRIVE) |-> $past(SCAN_TICK);
	endproperty
	property p_soft;
		(COMM_RST || PROT_RST) && !SCAN_TICK |=> $stable(RELAY_DRIVE);
	endproperty
	property p_rd_idle;
		!REG_RD |=> REG_RDATA == 32'h0;
	endproperty
	property p_rd_in;
		REG_RD && REG_ADDR == 8'h02 |=> REG_RDATA == {24'h0, $past(IN_STATE)};
	endproperty
	property p_rd_out;
		REG_RD && REG_ADDR == 8'h06 |=> REG_RDATA == {27'h0, $past(RELAY_DRIVE)};
	endproperty
	property p_rst;
		$rose(RST_B) |-> RELAY_DRIVE == 5'h0 && IN_STATE == 8'h0;
	endproperty
	a_period: assert property (p_period)
		else $error("scan tick spacing wrong");
	a_bound: assert property (p_bound)
		else $error("scan tick overdue");
	a_first: assert property (p_first)
		else $error("first scan tick after reset overdue");
	a_in_scan: assert property (p_in_scan)
		else $error("input state moved off scan");
	a_logic: assert property (p_logic)
		else $error("logic state not one scan behind");
	a_logic_hold: assert property (p_logic_hold)
		else $error("logic state moved off scan");
	a_relay: assert property (p_relay)
		else $error("relay moved off scan");
	a_soft: assert property (p_soft)
		else $error("soft reset moved relays");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero when idle");
	a_rd_in: assert property (p_rd_in)
		else $error("input state read wrong");
	a_rd_out: assert property (p_rd_out)
		else $error("relay read wrong");
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");
endmodule

bind dic_core dic_core_sva #(.MS_CYCLES(MS_CYCLES)) u_dic_core_sva (
	.SYS_CLK(SYS_CLK), .RST_B(RST_B), .COMM_RST(COMM_RST), .PROT_RST(PROT_RST),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.IN_STATE(IN_STATE), .LOGIC_STATE(LOGIC_STATE),
	.RELAY_DRIVE(RELAY_DRIVE), .SCAN_TICK(SCAN_TICK)
);

// ### verif/dic_field_model.sv
`timescale 1ns/1ps
module dic_field_model #(
	parameter int unsigned LAG = 2
) (
	input  wire logic       clk,
	input  wire logic [7:0] want,
	input  wire logic [4:0] coil,
	output logic      [7:0] field,
	output logic      [4:0] contact
);
	logic [8*LAG-1:0] pipe = '0;
	// Field wiring: a wanted input level lands LAG cycles late, LAG of 2 or more
	always @(posedge clk) begin
		pipe <= {pipe[8*LAG-9:0], want};
	end
	assign field = pipe[8*LAG-1 -: 8];
	// Energised coil closes its contact; mechanical travel not modelled
	assign contact = coil;
endmodule
